// ===== core/adcd_pkg.sv
/*
 * Shared constants of the converter card address decoder: window size,
 * region limits, control word layout and buffer geometry.
 * Assumes a 16-bit data path and a host that places each base on a
 * 128-byte boundary.
 */
package adcd_pkg;

   // =====================================================================
   // Window layout
   localparam int WIN_BITS = 7;
   localparam int ADDR_W = 32;
   localparam logic [WIN_BITS-1:0] CSR_FIRST = 7'h00;
   localparam logic [WIN_BITS-1:0] CSR_LAST = 7'h0E;
   localparam logic [WIN_BITS-1:0] BUF_FIRST = 7'h10;
   localparam logic [WIN_BITS-1:0] CHAN_LAST = 7'h2E;
   localparam logic [WIN_BITS-1:0] BUF_LAST = 7'h4E;
   localparam logic [WIN_BITS-1:0] RSV_FIRST = 7'h50;
   localparam logic [WIN_BITS-1:0] RSV_LAST = 7'h7E;

   // =====================================================================
   // Data and buffer geometry
   localparam int DATA_W = 16;
   localparam int BUF_WORDS = 32;
   localparam int BUF_IDX_W = 5;
   localparam int CHANNELS = 16;
   localparam int CHAN_W = 4;
   localparam int LANES = 2;

   // =====================================================================
   // Control word fields
   localparam logic [DATA_W-1:0] CSR_RESET = 16'h0000;
   localparam int SOFT_RESET_BIT = 14;
   localparam int SIGNED_FORMAT_SELECT_BIT = 12;
   localparam int RESULT_MSB = 15;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

endpackage : adcd_pkg

// ===== core/adcd_base_match.sv
/*
 * Compares a bus address with one base address and yields the hit and
 * the offset inside the 128-byte window.
 * Assumes the base is aligned to the window size; its low bits are ignored.
 */
`timescale 1ns/1ps

module adcd_base_match (
   // Address and base
   input wire logic [adcd_pkg::ADDR_W-1:0] base_i,
   input wire logic [adcd_pkg::ADDR_W-1:0] addr_i,
   // Result
   output logic hit_o,
   output logic [adcd_pkg::WIN_BITS-1:0] offset_o
);

   // =====================================================================
   // Decode
   always_comb begin
      hit_o = (addr_i[adcd_pkg::ADDR_W-1:adcd_pkg::WIN_BITS] ==
               base_i[adcd_pkg::ADDR_W-1:adcd_pkg::WIN_BITS]);
      offset_o = addr_i[adcd_pkg::WIN_BITS-1:0];
   end

endmodule : adcd_base_match

// ===== core/adcd_decoder.sv
/*
 * Address decoder and storage of the 16-channel converter card: control
 * word, 32-word result buffer, and capture of conversion results.
 * Assumes the host bus logic presents one-cycle requests with the space
 * already known, and that both base registers are held outside.
 */
// How it works
// - Claim 128 bytes from base, decode relative.
// - Sixteen-bit words; odd offsets alias even ones.
// - Offsets 00 to 0E all reach control word.
// - Offsets 10 to 4E map thirty-two buffer words.
// - Words 0 to 15 hold channel results.
// - Words 16 to 31 only host-written.
// - I/O window starts at first base.
// - Memory window starts at second base.
// - Software reset leaves buffer contents alone.
// - Signed select keeps bit 15, else inverts.
`timescale 1ns/1ps

module adcd_decoder (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Host access
   input wire logic req_i,
   input wire logic space_mem_i,
   input wire logic [adcd_pkg::ADDR_W-1:0] addr_i,
   input wire logic we_i,
   input wire logic [adcd_pkg::LANES-1:0] be_i,
   input wire logic [adcd_pkg::DATA_W-1:0] wdata_i,
   // Base address registers
   input wire logic [adcd_pkg::ADDR_W-1:0] io_base_i,
   input wire logic [adcd_pkg::ADDR_W-1:0] mem_base_i,
   // Converter results
   input wire logic conv_valid_i,
   input wire logic [adcd_pkg::CHAN_W-1:0] conv_channel_i,
   input wire logic [adcd_pkg::DATA_W-1:0] conv_data_i,
   // Host answer
   output logic claim_o,
   output logic ack_o,
   output logic [adcd_pkg::DATA_W-1:0] rdata_o,
   // Control outputs
   output logic [adcd_pkg::DATA_W-1:0] control_status_word_o,
   output logic soft_reset_o
);

   // =====================================================================
   // Window decode
   logic io_hit;
   logic mem_hit;
   logic [adcd_pkg::WIN_BITS-1:0] io_offset;
   logic [adcd_pkg::WIN_BITS-1:0] mem_offset;
   logic hit;
   logic [adcd_pkg::WIN_BITS-1:0] offset;
   logic [adcd_pkg::WIN_BITS-1:0] even_offset;
   logic sel_csr;
   logic sel_buf;
   logic [adcd_pkg::BUF_IDX_W-1:0] buf_idx;
   logic [adcd_pkg::WIN_BITS-1:0] buf_rel;

   adcd_base_match u_io_match (
      .base_i(io_base_i),
      .addr_i(addr_i),
      .hit_o(io_hit),
      .offset_o(io_offset)
   );

   adcd_base_match u_mem_match (
      .base_i(mem_base_i),
      .addr_i(addr_i),
      .hit_o(mem_hit),
      .offset_o(mem_offset)
   );

   always_comb begin
      if (space_mem_i) begin
         hit = req_i & mem_hit;
         offset = mem_offset;
      end else begin
         hit = req_i & io_hit;
         offset = io_offset;
      end
      // Bit 0 is dropped so an odd byte lands in its even word.
      even_offset = {offset[adcd_pkg::WIN_BITS-1:1], 1'b0};
      sel_csr = (even_offset <= adcd_pkg::CSR_LAST);
      sel_buf = (even_offset >= adcd_pkg::BUF_FIRST) && (even_offset <= adcd_pkg::BUF_LAST);
      buf_rel = even_offset - adcd_pkg::BUF_FIRST;
      buf_idx = buf_rel[adcd_pkg::BUF_IDX_W:1];
      claim_o = hit;
   end

   // =====================================================================
   // Storage state
   logic [adcd_pkg::DATA_W-1:0] control_status_word;
   logic [adcd_pkg::DATA_W-1:0] next_csr;
   logic [adcd_pkg::BUF_WORDS-1:0][adcd_pkg::DATA_W-1:0] buf_q;
   logic [adcd_pkg::BUF_WORDS-1:0][adcd_pkg::DATA_W-1:0] next_buf;
   logic next_soft_reset;
   logic ack;
   logic next_ack;
   logic [adcd_pkg::DATA_W-1:0] rdata;
   logic [adcd_pkg::DATA_W-1:0] next_rdata;
   logic host_wr;
   logic [adcd_pkg::DATA_W-1:0] stored_result;

   function automatic logic [adcd_pkg::DATA_W-1:0] merge_lanes(
      input logic [adcd_pkg::DATA_W-1:0] old_v,
      input logic [adcd_pkg::DATA_W-1:0] new_v,
      input logic [adcd_pkg::LANES-1:0] be
   );
      logic [adcd_pkg::DATA_W-1:0] res;
      res = old_v;
      if (be[0]) begin
         res[7:0] = new_v[7:0];
      end
      if (be[1]) begin
         res[15:8] = new_v[15:8];
      end
      return res;
   endfunction : merge_lanes

   always_comb begin
      host_wr = hit & we_i;
      // Converter output is two's complement; clear select turns it offset binary.
      stored_result = conv_data_i;
      stored_result[adcd_pkg::RESULT_MSB] = conv_data_i[adcd_pkg::RESULT_MSB] ^
         ~control_status_word[adcd_pkg::SIGNED_FORMAT_SELECT_BIT];
   end

   // Control word: a write with the reset bit set returns the word to its
   // reset value instead of storing, and pulses the reset line once.
   always_comb begin
      next_csr = control_status_word;
      next_soft_reset = 1'b0;
      if (host_wr && sel_csr) begin
         if (be_i[1] && wdata_i[adcd_pkg::SOFT_RESET_BIT]) begin
            next_csr = adcd_pkg::CSR_RESET;
            next_soft_reset = 1'b1;
         end else begin
            next_csr = merge_lanes(control_status_word, wdata_i, be_i);
         end
      end
   end

   // Buffer: host writes win over a result landing in the same word.
   // Soft reset never reaches this storage.
   genvar gi;
   generate
      for (gi = 0; gi < adcd_pkg::BUF_WORDS; gi++) begin : g_word
         always_comb begin
            next_buf[gi] = buf_q[gi];
            if (host_wr && sel_buf && (int'(buf_idx) == gi)) begin
               next_buf[gi] = merge_lanes(buf_q[gi], wdata_i, be_i);
            end else if ((gi < adcd_pkg::CHANNELS) && conv_valid_i &&
                         (int'(conv_channel_i) == gi)) begin
               next_buf[gi] = stored_result;
            end
         end
      end
   endgenerate

   // Every claimed access answers one cycle later; reserved space reads zero.
   always_comb begin
      next_ack = hit;
      next_rdata = adcd_pkg::READ_ZERO;
      if (hit && !we_i) begin
         if (sel_csr) begin
            next_rdata = control_status_word;
         end else if (sel_buf) begin
            next_rdata = buf_q[buf_idx];
         end
      end
   end

   // =====================================================================
   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         control_status_word <= adcd_pkg::CSR_RESET;
         soft_reset_o <= 1'b0;
         ack <= 1'b0;
         rdata <= adcd_pkg::READ_ZERO;
      end else begin
         control_status_word <= next_csr;
         soft_reset_o <= next_soft_reset;
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // Result storage has no reset: contents survive both resets.
   always_ff @(posedge clk_sys_i) begin
      buf_q <= next_buf;
   end

   always_comb begin
      ack_o = ack;
      rdata_o = rdata;
      control_status_word_o = control_status_word;
   end

   // =====================================================================
   // Checks
   chk_ack_after_claim: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      claim_o |=> ack_o)
      else $error("claimed access not acknowledged");

   chk_outside_silent: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !claim_o |=> !ack_o)
      else $error("unclaimed access acknowledged");

   chk_io_base_used: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i && !space_mem_i && (addr_i[adcd_pkg::ADDR_W-1:adcd_pkg::WIN_BITS] ==
       io_base_i[adcd_pkg::ADDR_W-1:adcd_pkg::WIN_BITS])) |-> claim_o)
      else $error("io window not claimed");

   chk_mem_base_used: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i && space_mem_i && (addr_i[adcd_pkg::ADDR_W-1:adcd_pkg::WIN_BITS] !=
       mem_base_i[adcd_pkg::ADDR_W-1:adcd_pkg::WIN_BITS])) |-> !claim_o)
      else $error("memory access outside window claimed");

   chk_csr_mirror_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (claim_o && !we_i && (offset < adcd_pkg::BUF_FIRST)) |=> (rdata_o == $past(control_status_word)))
      else $error("control word mirror read wrong");

   chk_buf_host_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (claim_o && we_i && sel_buf && (be_i == 2'h3)) |=> (buf_q[$past(buf_idx)] == $past(wdata_i)))
      else $error("buffer word not written");

   chk_result_format: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (conv_valid_i && !(host_wr && sel_buf)) |=>
      (buf_q[$past(conv_channel_i)] ==
       {$past(conv_data_i[adcd_pkg::RESULT_MSB]) ^ !$past(control_status_word[adcd_pkg::SIGNED_FORMAT_SELECT_BIT]),
        $past(conv_data_i[adcd_pkg::RESULT_MSB-1:0])}))
      else $error("result stored in wrong format");

   chk_spare_untouched: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !(host_wr && sel_buf && (buf_idx >= adcd_pkg::CHANNELS)) |=>
      $stable(buf_q[adcd_pkg::BUF_WORDS-1:adcd_pkg::CHANNELS]))
      else $error("spare words changed without host write");

   chk_reset_keeps_buf: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (host_wr && sel_csr && wdata_i[adcd_pkg::SOFT_RESET_BIT] && be_i[1] && !conv_valid_i) |=>
      ($stable(buf_q) && (control_status_word == adcd_pkg::CSR_RESET)))
      else $error("soft reset disturbed buffer or missed control word");

   chk_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (claim_o && (offset >= adcd_pkg::RSV_FIRST)) |=> (ack_o && (rdata_o == adcd_pkg::READ_ZERO)))
      else $error("reserved read not zero");

endmodule : adcd_decoder

// ===== dv/adcd_host_model.sv
/*
 * Host processor model: issues one-cycle read and write requests on the
 * decoder's host port and returns what the answer carried.
 * Assumes the decoder acks a claimed request one cycle after it is taken.
 */
`timescale 1ns/1ps

module adcd_host_model (
   // Clock
   input wire logic clk_sys_i,
   // Request
   output logic req_o,
   output logic space_mem_o,
   output logic [31:0] addr_o,
   output logic we_o,
   output logic [1:0] be_o,
   output logic [15:0] wdata_o,
   // Answer
   input wire logic ack_i,
   input wire logic [15:0] rdata_i
);
   initial begin
      req_o = 1'b0;
      space_mem_o = 1'b0;
      addr_o = 32'h0000_0000;
      we_o = 1'b0;
      be_o = 2'h3;
      wdata_o = 16'h0000;
   end

   // ======================================================================
   // Access task
   // The address and data lines are inverted after release so a stale value never matches.
   task automatic access(input logic sp, input logic [31:0] a, input logic w, input logic [1:0] lanes,
                         input logic [15:0] d, output logic [15:0] q, output logic hit);
      @(negedge clk_sys_i);
      req_o = 1'b1;
      space_mem_o = sp;
      addr_o = a;
      we_o = w;
      be_o = lanes;
      wdata_o = d;
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      req_o = 1'b0;
      hit = ack_i;
      q = rdata_i;
      addr_o = ~a;
      wdata_o = ~d;
   endtask : access
endmodule : adcd_host_model

// ===== dv/test_adc_board_address_decoder.sv
/*
 * Self-checking bench of the decoder: window claim, control word mirror,
 * buffer, reserved space, conversion capture and soft reset.
 * Assumes the host model above and a free-running 20 MHz clock.
 */
`timescale 1ns/1ps

module test_adc_board_address_decoder;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req, space_mem, we, claim, ack, soft_rst, hit;
   logic [1:0] be;
   logic [31:0] addr;
   logic [31:0] io_base = 32'h0000_1000;
   logic [31:0] mem_base = 32'hFEB0_0080;
   logic [15:0] wdata, rdata, control_status_word, q, d;
   logic conv_valid = 1'b0;
   logic [3:0] conv_ch = 4'h0;
   logic [15:0] conv_data = 16'h0000;
   logic [15:0] exp_buf [32];
   int err_total = 0;
   int comparisons = 0;
   int seed = 32122;
   int cycles = 0;
   logic claim_seen = 1'b0;

   always #25 clk_sys_i = ~clk_sys_i;

   // Claim is combinational, so it is caught at the edge that takes the request.
   always @(posedge clk_sys_i) begin
      if (req) begin
         claim_seen <= claim;
      end
   end

   adcd_host_model i_host (.clk_sys_i(clk_sys_i), .req_o(req), .space_mem_o(space_mem), .addr_o(addr),
      .we_o(we), .be_o(be), .wdata_o(wdata), .ack_i(ack), .rdata_i(rdata));

   adcd_decoder i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req), .space_mem_i(space_mem),
      .addr_i(addr), .we_i(we), .be_i(be), .wdata_i(wdata), .io_base_i(io_base), .mem_base_i(mem_base),
      .conv_valid_i(conv_valid), .conv_channel_i(conv_ch), .conv_data_i(conv_data), .claim_o(claim),
      .ack_o(ack), .rdata_o(rdata), .control_status_word_o(control_status_word), .soft_reset_o(soft_rst));

   // ======================================================================
   // Checking and closing
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      if (err_total == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end

   function automatic logic [15:0] conv_exp(input logic [15:0] raw, input logic sel);
      return {raw[15] ^ ~sel, raw[14:0]};
   endfunction : conv_exp

   // Picks a random space for each access, so traffic is spread over both windows.
   task automatic rw(input int off, input logic w, input logic [15:0] dd, input logic [1:0] lanes = 2'h3);
      logic sp;
      sp = 1'($random(seed) & 1);
      i_host.access(sp, (sp ? mem_base : io_base) + 32'(off), w, lanes, dd, q, hit);
      check({15'h0000, hit}, 16'h0001);
      check({15'h0000, claim_seen}, 16'h0001);
   endtask : rw

   // ======================================================================
   // Main sequence
   initial begin
      repeat (6) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      check(control_status_word, 16'h0000);
      d = 16'($random(seed)) & 16'hBFFF;
      rw(2 * ($random(seed) & 7), 1'b1, d);
      for (int i = 0; i < 8; i++) begin
         rw(2 * i, 1'b0, 16'h0000);
         check(q, d);
      end
      for (int i = 0; i < 32; i++) begin
         exp_buf[i] = 16'($random(seed));
         rw(16 + 2 * i, 1'b1, exp_buf[i]);
      end
      for (int i = 0; i < 32; i++) begin
         rw(17 + 2 * i, 1'b0, 16'h0000);
         check(q, exp_buf[i]);
      end
      d = 16'($random(seed));
      rw(22, 1'b1, d, 2'h2);
      exp_buf[3][15:8] = d[15:8];
      rw(22, 1'b0, 16'h0000);
      check(q, exp_buf[3]);
      for (int i = 40; i < 64; i++) begin
         rw(2 * i, 1'b1, 16'hFFFF);
         rw(2 * i, 1'b0, 16'h0000);
         check(q, 16'h0000);
      end
      i_host.access(1'b0, io_base + 32'h80, 1'b0, 2'h3, 16'h0000, q, hit);
      check({15'h0000, hit}, 16'h0000);
      check({15'h0000, claim_seen}, 16'h0000);
      i_host.access(1'b1, io_base, 1'b0, 2'h3, 16'h0000, q, hit);
      check({15'h0000, hit}, 16'h0000);
      check({15'h0000, claim_seen}, 16'h0000);
      for (int s = 0; s < 2; s++) begin
         rw(0, 1'b1, s[0] ? 16'h1000 : 16'h0000);
         for (int c = 0; c < 16; c++) begin
            @(negedge clk_sys_i);
            conv_valid = 1'b1;
            conv_ch = 4'(c);
            conv_data = (c == 0) ? 16'h8000 : 16'($random(seed));
            exp_buf[c] = conv_exp(conv_data, s[0]);
         end
         @(negedge clk_sys_i);
         conv_valid = 1'b0;
         for (int i = 0; i < 32; i++) begin
            rw(16 + 2 * i, 1'b0, 16'h0000);
            check(q, exp_buf[i]);
         end
      end
      rw(0, 1'b1, 16'h4000);
      check({15'h0000, soft_rst}, 16'h0001);
      check(control_status_word, 16'h0000);
      for (int i = 0; i < 32; i++) begin
         rw(16 + 2 * i, 1'b0, 16'h0000);
         check(q, exp_buf[i]);
      end
      close_out();
   end
endmodule : test_adc_board_address_decoder
